// file: inc/psv_regs.vh
// Constants for the program space vector logic
`ifndef PSV_REGS_VH
`define PSV_REGS_VH
`define PSV_PC_W 21
`define PSV_DATA_W 16
`define PSV_SP_W 5
`define PSV_STACK_DEPTH 31
`define PSV_RESET_VEC 21'h000000
`define PSV_HIGH_VEC 21'h000008
`define PSV_LOW_VEC 21'h000018
`define PSV_PC_STEP 21'h000002
`define PSV_FLASH_32K 21'h008000
`define PSV_FLASH_64K 21'h010000
`define PSV_FLASH_128K 21'h020000
`define PSV_WORDS_32K 16384
`define PSV_NOP_WORD 16'h0000
`define PSV_SP_RESET 5'h00
`define PSV_SP_FULL 5'h1F
`endif

// file: sim/psv_core_assertions.sv
// Port checker for the core
`timescale 1ns/1ps
`default_nettype none
module psv_chk #(
	parameter FLASH_KBYTES = 128
) (
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic FETCH_EN,
	input wire logic IRQ_ACK,
	input wire logic IRQ_HIGH_PRIO,
	input wire logic SLEEPING,
	input wire logic WAKE_IRQ,
	input wire logic HIGH_PRIORITY_GLOBAL_IRQ_ENABLE,
	input wire logic LOW_PRIORITY_GLOBAL_IRQ_ENABLE,
	input wire logic JUMP_EN,
	input wire logic [20:0] JUMP_ADDR,
	input wire logic AWAKE,
	input wire logic [15:0] INSTR_DATA,
	input wire logic [20:0] FLASH_ADDR,
	input wire logic [20:0] PC,
	input wire logic [20:0] STACK_TOP,
	input wire logic [4:0] RETURN_STACK_POINTER
);
	wire a = FLASH_ADDR < FLASH_KBYTES * 1024;
	wire r = AWAKE & !SLEEPING & IRQ_ACK;
	wire g = HIGH_PRIORITY_GLOBAL_IRQ_ENABLE | LOW_PRIORITY_GLOBAL_IRQ_ENABLE;
	wire [20:0] v = IRQ_HIGH_PRIO ? 21'h8 : 21'h18;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	chk_pc_even: assert property (!PC[0] && FLASH_ADDR == PC) else $error("pc");
	chk_pc_step: assert property (!r && AWAKE && !SLEEPING && !JUMP_EN && FETCH_EN
		|=> PC == $past(PC) + 21'h2) else $error("step");
	chk_irq_vec: assert property (r |=> PC == $past(v)) else $error("vec");
	chk_irq_push: assert property (r && RETURN_STACK_POINTER < 5'h1F
		|=> STACK_TOP == $past(PC)) else $error("push");
	chk_wake_vec: assert property (!AWAKE && WAKE_IRQ && g
		|=> PC == $past(v)) else $error("wake");
	chk_wake_push: assert property (!AWAKE && WAKE_IRQ && g && RETURN_STACK_POINTER != 5'h1F
		|=> STACK_TOP == $past(PC)) else $error("wake push");
	chk_wake_none: assert property (!AWAKE && WAKE_IRQ && !g
		|=> $stable(PC) && $stable(RETURN_STACK_POINTER)) else $error("none");
	chk_jump_even: assert property (AWAKE && !SLEEPING && !IRQ_ACK && JUMP_EN
		|=> PC == ($past(JUMP_ADDR) & 21'h1FFFFE)) else $error("jump");
	chk_sp_push: assert property (r && RETURN_STACK_POINTER != 5'h1F
		|=> RETURN_STACK_POINTER == $past(RETURN_STACK_POINTER) + 5'h01) else $error("sp");
	chk_stack_keep: assert property (r && RETURN_STACK_POINTER == 5'h1F
		|=> RETURN_STACK_POINTER == 5'h1F && $stable(STACK_TOP)) else $error("keep");
	chk_zero_fill: assert property (!a |=> INSTR_DATA == 16'h0) else $error("zero");
	chk_sleep_hold: assert property (!AWAKE && !WAKE_IRQ |=> $stable(PC)) else $error("hold");
	chk_reset_pc: assert property (disable iff (1'b0) !RSTN |=> PC == 21'h0
		&& RETURN_STACK_POINTER == 5'h0) else $error("rst");
	cover property (r);
	cover property (!AWAKE && WAKE_IRQ);
	cover property (!a);
	cover property (r && RETURN_STACK_POINTER == 5'h1F);
endmodule
bind psv_core psv_chk #(.FLASH_KBYTES(FLASH_KBYTES)) u_psv_chk (
	.SYS_CLK(SYS_CLK),
	.RSTN(RSTN),
	.FETCH_EN(FETCH_EN),
	.IRQ_ACK(IRQ_ACK),
	.IRQ_HIGH_PRIO(IRQ_HIGH_PRIO),
	.SLEEPING(SLEEPING),
	.WAKE_IRQ(WAKE_IRQ),
	.HIGH_PRIORITY_GLOBAL_IRQ_ENABLE(HIGH_PRIORITY_GLOBAL_IRQ_ENABLE),
	.LOW_PRIORITY_GLOBAL_IRQ_ENABLE(LOW_PRIORITY_GLOBAL_IRQ_ENABLE),
	.JUMP_EN(JUMP_EN),
	.JUMP_ADDR(JUMP_ADDR),
	.AWAKE(AWAKE),
	.INSTR_DATA(INSTR_DATA),
	.FLASH_ADDR(FLASH_ADDR),
	.PC(PC),
	.STACK_TOP(STACK_TOP),
	.RETURN_STACK_POINTER(RETURN_STACK_POINTER)
);
`default_nettype wire

// file: sim/psv_flash.sv
// Program flash model
`timescale 1ns/1ps
`default_nettype none
module psv_flash (
	input wire [20:0] FLASH_ADDR,
	output logic [15:0] FLASH_RDATA
);
	// Aliases above its size, so the core must mask it
	assign FLASH_RDATA = FLASH_ADDR[15:0] ^ 16'hA5C3;
endmodule
`default_nettype wire

// file: sim/tb.sv
// Core bench
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic SYS_CLK = 0, RSTN = 0, FETCH_EN = 0, IRQ_ACK = 0, IRQ_HIGH_PRIO = 1, SLEEPING = 0;
	logic WAKE_IRQ = 0, HIGH_PRIORITY_GLOBAL_IRQ_ENABLE = 0, LOW_PRIORITY_GLOBAL_IRQ_ENABLE = 1;
	logic JUMP_EN = 0, STACK_FULL, AWAKE;
	logic [20:0] JUMP_ADDR = 0, FLASH_ADDR, PC, STACK_TOP;
	logic [15:0] FLASH_RDATA, INSTR_DATA;
	logic [4:0] RETURN_STACK_POINTER;
	int bad_count = 0, n_tests = 0, cyc = 0;
	always #4 SYS_CLK = ~SYS_CLK;
	psv_flash u_psv_flash (.*);
	psv_core #(.FLASH_KBYTES(32)) u_psv_core (.*);
	task wrap_up;
		$display("%0d checks %0d bad", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task cmp(input logic [20:0] g, e);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %0t %h %h", $time, g, e);
		end
	endtask
	task go(input int n);
		repeat (n) @(posedge SYS_CLK);
		#1;
	endtask
	always @(posedge SYS_CLK) if (++cyc > 200) begin
		bad_count++;
		wrap_up;
	end
	task t_fetch;
		FETCH_EN = 1;
		go(3);
		FETCH_EN = 0;
		cmp(PC, 21'h6);
		cmp({5'h0, INSTR_DATA}, 21'hA5C7);
		$display("fetch end");
	endtask
	task t_irq;
		IRQ_ACK = 1;
		go(1);
		IRQ_HIGH_PRIO = 0;
		cmp(PC, 21'h8);
		cmp({16'h0000, RETURN_STACK_POINTER}, 21'h1);
		cmp(STACK_TOP, 21'h6);
		go(1);
		IRQ_ACK = 0;
		cmp(PC, 21'h18);
		$display("irq end");
	endtask
	task t_zero;
		JUMP_EN = 1;
		JUMP_ADDR = 21'h7FFF;
		go(2);
		JUMP_ADDR = 21'h8000;
		cmp(PC, 21'h7FFE);
		cmp(FLASH_ADDR, 21'h7FFE);
		cmp({5'h0, INSTR_DATA}, 21'hDA3D);
		go(2);
		JUMP_EN = 0;
		cmp({5'h0, INSTR_DATA}, 21'h0);
		$display("zero end");
	endtask
	task nap;
		SLEEPING = 1;
		go(1);
		SLEEPING = 0;
		cmp({20'h00000, AWAKE}, 21'h0);
		WAKE_IRQ = 1;
		go(1);
		WAKE_IRQ = 0;
	endtask
	task t_wake;
		nap;
		cmp(PC, 21'h18);
		cmp(STACK_TOP, 21'h8000);
		cmp({20'h00000, AWAKE}, 21'h1);
		LOW_PRIORITY_GLOBAL_IRQ_ENABLE = 0;
		nap;
		cmp(PC, 21'h18);
		cmp({16'h0000, RETURN_STACK_POINTER}, 21'h3);
		HIGH_PRIORITY_GLOBAL_IRQ_ENABLE = 1;
		IRQ_HIGH_PRIO = 1;
		nap;
		cmp(PC, 21'h8);
		cmp(STACK_TOP, 21'h18);
		$display("wake end");
	endtask
	task t_full;
		IRQ_ACK = 1;
		go(27);
		cmp({16'h0000, RETURN_STACK_POINTER}, 21'h1F);
		cmp({20'h00000, STACK_FULL}, 21'h1);
		IRQ_HIGH_PRIO = 0;
		go(2);
		IRQ_ACK = 0;
		cmp(PC, 21'h18);
		cmp(STACK_TOP, 21'h8);
		cmp({16'h0000, RETURN_STACK_POINTER}, 21'h1F);
		$display("full end");
	endtask
	task t_reset;
		RSTN = 0;
		go(2);
		RSTN = 1;
		cmp(PC, 21'h0);
		cmp(FLASH_ADDR, 21'h0);
		cmp({16'h0000, RETURN_STACK_POINTER}, 21'h0);
		cmp({20'h00000, STACK_FULL}, 21'h0);
		cmp({5'h00, INSTR_DATA}, 21'h0);
		$display("reset end");
	endtask
	initial begin
		go(12);
		RSTN = 1;
		cmp(PC, 21'h0);
		t_fetch;
		t_irq;
		t_zero;
		t_wake;
		t_full;
		t_reset;
		t_fetch;
		wrap_up;
	end
endmodule
`default_nettype wire

// file: verilog/psv_core.v
// Program counter, hard vectors and wake-up vectoring for the fetch path
`timescale 1ns/1ps
`default_nettype none
`include "psv_regs.vh"
// How it works
// - Fetch port to flash is separate from any data bus, running concurrently.
// - Program counter is 21 bits, byte addressed, 2 Mbyte space.
// - Reads above implemented flash return zero, a no-operation.
// - Flash size parameter selects 32, 64 or 128 Kbytes.
// - One single-word instruction takes two bytes of program space.
// - Every reset loads the program counter with 0000h.
// - Interrupt service vectors to 0008h high or 0018h low.
// - Interrupt wake from sleep with a global enable loads that vector.
// - Such a wake pushes the current counter onto the return stack first when the stack is not full.
// - Counter bit zero stays zero; sequential fetch adds two.
// - Reset clears the return stack pointer to zero, an empty slot.
module psv_core #(
	parameter FLASH_KBYTES = 128
) (
	input wire SYS_CLK,
	input wire RSTN,
	input wire FETCH_EN,
	input wire IRQ_ACK,
	input wire IRQ_HIGH_PRIO,
	input wire SLEEPING,
	input wire WAKE_IRQ,
	input wire HIGH_PRIORITY_GLOBAL_IRQ_ENABLE,
	input wire LOW_PRIORITY_GLOBAL_IRQ_ENABLE,
	input wire JUMP_EN,
	input wire [20:0] JUMP_ADDR,
	input wire [15:0] FLASH_RDATA,
	output reg [20:0] FLASH_ADDR,
	output wire [15:0] INSTR_DATA,
	output reg [20:0] PC,
	output reg [4:0] RETURN_STACK_POINTER,
	output reg [20:0] STACK_TOP,
	output reg STACK_FULL,
	output reg AWAKE
);
	// ----------------------------------------
	// Sizing
	// ----------------------------------------
	localparam [20:0] FLASH_BYTES = (FLASH_KBYTES == 32) ? `PSV_FLASH_32K :
		(FLASH_KBYTES == 64) ? `PSV_FLASH_64K : `PSV_FLASH_128K;
	// Only the two states below exist; any other code falls back to run
	localparam [1:0] ST_RUN = 2'b01;
	localparam [1:0] ST_SLEEP = 2'b10;

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [20:0] pc_next;
	reg push;
	reg push_ok;
	reg awake_next;
	reg [4:0] sp_next;
	reg [20:0] tos_next;
	reg full_next;
	reg [20:0] stack_mem [1:31];
	wire [4:0] sp_inc;
	wire wake_vec;

	// ----------------------------------------
	// Wake and push qualifiers
	// ----------------------------------------
	assign sp_inc = RETURN_STACK_POINTER + 5'h01;
	// A wake with both enables clear resumes in place, with no vector and no push
	assign wake_vec = WAKE_IRQ &
		(HIGH_PRIORITY_GLOBAL_IRQ_ENABLE | LOW_PRIORITY_GLOBAL_IRQ_ENABLE);

	// Clear bit zero so the counter never lands between the bytes of a word
	function [20:0] even_addr;
		input [20:0] a;
		begin
			even_addr = {a[20:1], 1'b0};
		end
	endfunction

	// Pushes stop at the top slot; slot zero is only the empty mark
	function has_room;
		input [4:0] sp;
		begin
			has_room = (sp != `PSV_SP_FULL);
		end
	endfunction

	// Pick the vector by acknowledged priority
	function [20:0] vec_sel;
		input high;
		begin
			vec_sel = high ? `PSV_HIGH_VEC : `PSV_LOW_VEC;
		end
	endfunction

	// ----------------------------------------
	// Next program counter
	// ----------------------------------------
	always @* begin
		state_next = state_reg;
		pc_next = PC;
		push = 1'b0;
		case (state_reg)
			ST_RUN: begin
				if (SLEEPING) begin
					state_next = ST_SLEEP;
				end else if (IRQ_ACK) begin
					pc_next = vec_sel(IRQ_HIGH_PRIO);
					push = 1'b1;
				end else if (JUMP_EN) begin
					pc_next = even_addr(JUMP_ADDR);
				end else if (FETCH_EN) begin
					pc_next = PC + `PSV_PC_STEP;
				end
			end
			ST_SLEEP: begin
				if (WAKE_IRQ) begin
					state_next = ST_RUN;
					if (wake_vec) begin
						pc_next = vec_sel(IRQ_HIGH_PRIO);
						push = 1'b1;
					end
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
	end

	// ----------------------------------------
	// Return stack next values
	// ----------------------------------------
	// A full stack keeps its 31st entry rather than overwriting it; the counter still vectors
	always @* begin
		push_ok = push & has_room(RETURN_STACK_POINTER);
		sp_next = RETURN_STACK_POINTER;
		tos_next = STACK_TOP;
		full_next = STACK_FULL;
		if (push_ok) begin
			sp_next = sp_inc;
			tos_next = PC;
			full_next = STACK_FULL | (sp_inc == `PSV_SP_FULL);
		end
	end

	// ----------------------------------------
	// Sequencer state
	// ----------------------------------------
	always @* begin
		awake_next = (state_next == ST_RUN);
	end

	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			state_reg <= ST_RUN;
			AWAKE <= 1'b1;
		end else begin
			state_reg <= state_next;
			AWAKE <= awake_next;
		end
	end

	// ----------------------------------------
	// Program counter
	// ----------------------------------------
	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			PC <= `PSV_RESET_VEC;
		end else begin
			PC <= even_addr(pc_next);
		end
	end

	// ----------------------------------------
	// Fetch address
	// ----------------------------------------
	// A twin of the counter, so the flash address comes straight off a flop
	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			FLASH_ADDR <= `PSV_RESET_VEC;
		end else begin
			FLASH_ADDR <= even_addr(pc_next);
		end
	end

	// ----------------------------------------
	// Return stack pointer, top copy and full flag
	// ----------------------------------------
	always @(posedge SYS_CLK) begin
		if (!RSTN) begin
			RETURN_STACK_POINTER <= `PSV_SP_RESET;
			STACK_TOP <= `PSV_RESET_VEC;
			STACK_FULL <= 1'b0;
		end else begin
			RETURN_STACK_POINTER <= sp_next;
			STACK_TOP <= tos_next;
			STACK_FULL <= full_next;
		end
	end

	// ----------------------------------------
	// Return stack storage
	// ----------------------------------------
	// Written only on an accepted push; the top is mirrored in STACK_TOP for reads
	always @(posedge SYS_CLK) begin
		if (RSTN && push_ok) begin
			stack_mem[sp_inc] <= PC;
		end
	end

	// ----------------------------------------
	// Fetch data path
	// ----------------------------------------
	psv_fetch_gate #(
		.FLASH_BYTES(FLASH_BYTES)
	) u_gate (
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.addr(FLASH_ADDR),
		.flash_rdata(FLASH_RDATA),
		.rdata_reg(INSTR_DATA)
	);
endmodule
`default_nettype wire

// file: verilog/psv_fetch_gate.v
// Program flash fetch gate: zero fill above implemented flash
`timescale 1ns/1ps
`default_nettype none
`include "psv_regs.vh"
module psv_fetch_gate #(
	parameter [20:0] FLASH_BYTES = `PSV_FLASH_128K
) (
	input wire clk,
	input wire rst_n,
	input wire [20:0] addr,
	input wire [15:0] flash_rdata,
	output reg [15:0] rdata_reg
);
	// Word count of the part is FLASH_BYTES/2, e.g. 16384 for 32 Kbytes
	function in_flash;
		input [20:0] a;
		begin
			in_flash = (a < FLASH_BYTES);
		end
	endfunction
	always @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= `PSV_NOP_WORD;
		end else if (in_flash(addr)) begin
			rdata_reg <= flash_rdata;
		end else begin
			rdata_reg <= `PSV_NOP_WORD;
		end
	end
endmodule
`default_nettype wire
